// >>> core/ipe_regs.sv
`timescale 1ns/1ns
`include "ipe_params.svh"

module ipe_regs
    import ipe_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [`IPE_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`IPE_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`IPE_NUM_SRC-1:0] src_req,
    input wire logic [`IPE_NUM_SRC-2:0] src_enable,
    input wire logic [2:0] usb_level,
    output logic usb_irq_enable,
    output ipe_levels_t levels,
    output ipe_grant_t grant
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic addr_is(input logic [`IPE_ADDR_W-1:0] a,
                                     input logic [`IPE_ADDR_W-1:0] off);
        addr_is = (a == off);
    endfunction

    function automatic logic [2:0] field(input logic [15:0] r, input int lsb);
        field = r[lsb +: 3];
    endfunction

    function automatic logic addr_mapped(input logic [`IPE_ADDR_W-1:0] a);
        addr_mapped = addr_is(a, `IPE_OFF_EN5) || addr_is(a, `IPE_OFF_LVL0)
                   || addr_is(a, `IPE_OFF_LVL1) || addr_is(a, `IPE_OFF_LVL2)
                   || addr_is(a, `IPE_OFF_LVL3) || addr_is(a, `IPE_OFF_LVL4)
                   || addr_is(a, `IPE_OFF_STAT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel

    typedef enum logic {WR_COLLECT, WR_RESP} ipe_wr_state_t;
    typedef enum logic {RD_IDLE, RD_DATA} ipe_rd_state_t;

    ipe_wr_state_t wr_state_q;
    logic aw_have_q;
    logic w_have_q;
    logic [`IPE_ADDR_W-1:0] aw_addr_q;
    logic [15:0] w_data_q;
    logic [1:0] w_strb_q;
    logic [1:0] bresp_q;
    logic aw_hs;
    logic w_hs;
    logic wr_go;

    assign s_axi_awready = (wr_state_q == WR_COLLECT) && !aw_have_q;
    assign s_axi_wready = (wr_state_q == WR_COLLECT) && !w_have_q;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    // Commit one cycle after both halves are held; simpler than a bypass path
    assign wr_go = (wr_state_q == WR_COLLECT) && aw_have_q && w_have_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (aw_hs)
        begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (wr_go)
        begin
            aw_have_q <= 1'b0;
        end
    end

    // Upper byte lanes carry nothing: registers are 16 bits
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else if (w_hs)
        begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_strb_q <= s_axi_wstrb[1:0];
        end
        else if (wr_go)
        begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_state_q <= WR_COLLECT;
        end
        else
        begin
            case (wr_state_q)
                WR_COLLECT:
                begin
                    if (wr_go)
                    begin
                        wr_state_q <= WR_RESP;
                    end
                end
                WR_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wr_state_q <= WR_COLLECT;
                    end
                end
                default:
                begin
                    wr_state_q <= WR_COLLECT;
                end
            endcase
        end
    end

    // Status word is read-only: a write there answers OKAY and changes nothing
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bresp_q <= `IPE_RESP_OKAY;
        end
        else if (wr_go)
        begin
            bresp_q <= addr_mapped(aw_addr_q) ? `IPE_RESP_OKAY : `IPE_RESP_SLVERR;
        end
    end

    assign s_axi_bvalid = (wr_state_q == WR_RESP);
    assign s_axi_bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Register bank

    logic [15:0] en5_r;
    logic [15:0] lvl0_r;
    logic [15:0] lvl1_r;
    logic [15:0] lvl2_r;
    logic [15:0] lvl3_r;
    logic [15:0] lvl4_r;

    ipe_reg16 #(.IMPL_MASK(`IPE_MASK_EN5), .RESET_VAL(`IPE_RST_EN5)) u_en5
    (
        .clk(clk),
        .resetn(resetn),
        .we(wr_go && addr_is(aw_addr_q, `IPE_OFF_EN5)),
        .wdata(w_data_q),
        .wstrb(w_strb_q),
        .q(en5_r)
    );

    ipe_reg16 #(.IMPL_MASK(`IPE_MASK_LVL0), .RESET_VAL(`IPE_RST_LVL0)) u_lvl0
    (
        .clk(clk),
        .resetn(resetn),
        .we(wr_go && addr_is(aw_addr_q, `IPE_OFF_LVL0)),
        .wdata(w_data_q),
        .wstrb(w_strb_q),
        .q(lvl0_r)
    );

    ipe_reg16 #(.IMPL_MASK(`IPE_MASK_LVL1), .RESET_VAL(`IPE_RST_LVL1)) u_lvl1
    (
        .clk(clk),
        .resetn(resetn),
        .we(wr_go && addr_is(aw_addr_q, `IPE_OFF_LVL1)),
        .wdata(w_data_q),
        .wstrb(w_strb_q),
        .q(lvl1_r)
    );

    ipe_reg16 #(.IMPL_MASK(`IPE_MASK_LVL2), .RESET_VAL(`IPE_RST_LVL2)) u_lvl2
    (
        .clk(clk),
        .resetn(resetn),
        .we(wr_go && addr_is(aw_addr_q, `IPE_OFF_LVL2)),
        .wdata(w_data_q),
        .wstrb(w_strb_q),
        .q(lvl2_r)
    );

    ipe_reg16 #(.IMPL_MASK(`IPE_MASK_LVL3), .RESET_VAL(`IPE_RST_LVL3)) u_lvl3
    (
        .clk(clk),
        .resetn(resetn),
        .we(wr_go && addr_is(aw_addr_q, `IPE_OFF_LVL3)),
        .wdata(w_data_q),
        .wstrb(w_strb_q),
        .q(lvl3_r)
    );

    ipe_reg16 #(.IMPL_MASK(`IPE_MASK_LVL4), .RESET_VAL(`IPE_RST_LVL4)) u_lvl4
    (
        .clk(clk),
        .resetn(resetn),
        .we(wr_go && addr_is(aw_addr_q, `IPE_OFF_LVL4)),
        .wdata(w_data_q),
        .wstrb(w_strb_q),
        .q(lvl4_r)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Field unpacking

    always_comb
    begin
        levels.timer_one_level = field(lvl0_r, `IPE_FLD_HI);
        levels.compare_one_level = field(lvl0_r, `IPE_FLD_MH);
        levels.capture_one_level = field(lvl0_r, `IPE_FLD_ML);
        levels.ext_pin_zero_level = field(lvl0_r, `IPE_FLD_LO);
        levels.timer_two_level = field(lvl1_r, `IPE_FLD_HI);
        levels.compare_two_level = field(lvl1_r, `IPE_FLD_MH);
        levels.capture_two_level = field(lvl1_r, `IPE_FLD_ML);
        levels.serial_one_rx_level = field(lvl2_r, `IPE_FLD_HI);
        levels.sync_serial_one_event_level = field(lvl2_r, `IPE_FLD_MH);
        levels.sync_serial_one_fault_level = field(lvl2_r, `IPE_FLD_ML);
        levels.timer_three_level = field(lvl2_r, `IPE_FLD_LO);
        levels.converter_done_level = field(lvl3_r, `IPE_FLD_ML);
        levels.serial_one_tx_level = field(lvl3_r, `IPE_FLD_LO);
        levels.pin_change_level = field(lvl4_r, `IPE_FLD_HI);
        levels.comparator_level = field(lvl4_r, `IPE_FLD_MH);
        levels.twowire_one_master_level = field(lvl4_r, `IPE_FLD_ML);
        levels.twowire_one_slave_level = field(lvl4_r, `IPE_FLD_LO);
    end

    assign usb_irq_enable = en5_r[`IPE_USB_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Arbitration

    logic [`IPE_NUM_SRC-1:0] eff_en;
    logic [3*`IPE_NUM_SRC-1:0] lvl_flat;

    // USB level lives in a register outside this block
    assign eff_en = {usb_irq_enable, src_enable};
    assign lvl_flat = {usb_level,
                       levels.twowire_one_slave_level,
                       levels.twowire_one_master_level,
                       levels.comparator_level,
                       levels.pin_change_level,
                       levels.serial_one_tx_level,
                       levels.converter_done_level,
                       levels.timer_three_level,
                       levels.sync_serial_one_fault_level,
                       levels.sync_serial_one_event_level,
                       levels.serial_one_rx_level,
                       levels.capture_two_level,
                       levels.compare_two_level,
                       levels.timer_two_level,
                       levels.ext_pin_zero_level,
                       levels.capture_one_level,
                       levels.compare_one_level,
                       levels.timer_one_level};

    ipe_arbiter u_arb
    (
        .clk(clk),
        .resetn(resetn),
        .req(src_req),
        .en(eff_en),
        .lvl(lvl_flat),
        .grant(grant)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel

    ipe_rd_state_t rd_state_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [15:0] rd_word;
    logic [15:0] stat_word;
    logic ar_hs;

    assign s_axi_arready = (rd_state_q == RD_IDLE);
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        stat_word = '0;
        stat_word[2:0] = grant.level;
        stat_word[`IPE_STAT_SRC_LSB +: 5] = grant.source;
        stat_word[`IPE_STAT_VALID_BIT] = grant.valid;
    end

    // Register outputs are already masked, so holes read zero
    always_comb
    begin
        case (s_axi_araddr)
            `IPE_OFF_EN5: rd_word = en5_r;
            `IPE_OFF_LVL0: rd_word = lvl0_r;
            `IPE_OFF_LVL1: rd_word = lvl1_r;
            `IPE_OFF_LVL2: rd_word = lvl2_r;
            `IPE_OFF_LVL3: rd_word = lvl3_r;
            `IPE_OFF_LVL4: rd_word = lvl4_r;
            `IPE_OFF_STAT: rd_word = stat_word;
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_q <= '0;
            rresp_q <= `IPE_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= addr_mapped(s_axi_araddr) ? `IPE_RESP_OKAY : `IPE_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_state_q <= RD_IDLE;
        end
        else
        begin
            case (rd_state_q)
                RD_IDLE:
                begin
                    if (ar_hs)
                    begin
                        rd_state_q <= RD_DATA;
                    end
                end
                RD_DATA:
                begin
                    if (s_axi_rready)
                    begin
                        rd_state_q <= RD_IDLE;
                    end
                end
                default:
                begin
                    rd_state_q <= RD_IDLE;
                end
            endcase
        end
    end

    assign s_axi_rvalid = (rd_state_q == RD_DATA);
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

// >>> core/ipe_params.svh
`ifndef IPE_PARAMS_SVH
`define IPE_PARAMS_SVH

`define IPE_ADDR_W 8
`define IPE_OFF_EN5 8'h00
`define IPE_OFF_LVL0 8'h04
`define IPE_OFF_LVL1 8'h08
`define IPE_OFF_LVL2 8'h0C
`define IPE_OFF_LVL3 8'h10
`define IPE_OFF_LVL4 8'h14
`define IPE_OFF_STAT 8'h18

`define IPE_MASK_EN5 16'h0040
`define IPE_MASK_LVL0 16'h7777
`define IPE_MASK_LVL1 16'h7770
`define IPE_MASK_LVL2 16'h7777
`define IPE_MASK_LVL3 16'h0077
`define IPE_MASK_LVL4 16'h7777

`define IPE_RST_EN5 16'h0000
`define IPE_RST_LVL0 16'h4444
`define IPE_RST_LVL1 16'h4440
`define IPE_RST_LVL2 16'h4444
`define IPE_RST_LVL3 16'h0044
`define IPE_RST_LVL4 16'h4444

`define IPE_USB_EN_BIT 6
`define IPE_FLD_HI 12
`define IPE_FLD_MH 8
`define IPE_FLD_ML 4
`define IPE_FLD_LO 0

`define IPE_STAT_SRC_LSB 4
`define IPE_STAT_VALID_BIT 15

`define IPE_LVL_OFF 3'h0
`define IPE_NUM_SRC 18

`define IPE_RESP_OKAY 2'h0
`define IPE_RESP_SLVERR 2'h2

`endif

// >>> core/ipe_pkg.sv
package ipe_pkg;

    typedef enum logic [4:0] {
        SRC_TIMER_ONE,
        SRC_COMPARE_ONE,
        SRC_CAPTURE_ONE,
        SRC_EXT_PIN_ZERO,
        SRC_TIMER_TWO,
        SRC_COMPARE_TWO,
        SRC_CAPTURE_TWO,
        SRC_SERIAL_ONE_RX,
        SRC_SYNC_SERIAL_ONE_EVENT,
        SRC_SYNC_SERIAL_ONE_FAULT,
        SRC_TIMER_THREE,
        SRC_CONVERTER_DONE,
        SRC_SERIAL_ONE_TX,
        SRC_PIN_CHANGE,
        SRC_COMPARATOR,
        SRC_TWOWIRE_ONE_MASTER,
        SRC_TWOWIRE_ONE_SLAVE,
        SRC_USB
    } ipe_src_t;

    typedef struct packed {
        logic [2:0] timer_one_level;
        logic [2:0] compare_one_level;
        logic [2:0] capture_one_level;
        logic [2:0] ext_pin_zero_level;
        logic [2:0] timer_two_level;
        logic [2:0] compare_two_level;
        logic [2:0] capture_two_level;
        logic [2:0] serial_one_rx_level;
        logic [2:0] sync_serial_one_event_level;
        logic [2:0] sync_serial_one_fault_level;
        logic [2:0] timer_three_level;
        logic [2:0] converter_done_level;
        logic [2:0] serial_one_tx_level;
        logic [2:0] pin_change_level;
        logic [2:0] comparator_level;
        logic [2:0] twowire_one_master_level;
        logic [2:0] twowire_one_slave_level;
    } ipe_levels_t;

    typedef struct packed {
        logic valid;
        logic [2:0] level;
        ipe_src_t source;
    } ipe_grant_t;

endpackage

// >>> core/ipe_reg16.sv
`timescale 1ns/1ns
`include "ipe_params.svh"

module ipe_reg16
#(
    parameter logic [15:0] IMPL_MASK = 16'h0000,
    parameter logic [15:0] RESET_VAL = 16'h0000
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic we,
    input wire logic [15:0] wdata,
    input wire logic [1:0] wstrb,
    output logic [15:0] q
);

    logic [15:0] q_q;
    logic [15:0] lane_mask;

    assign lane_mask = {{8{wstrb[1]}}, {8{wstrb[0]}}} & IMPL_MASK;

    // Unimplemented bits never store; they stay at constant zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q_q <= RESET_VAL & IMPL_MASK;
        end
        else if (we)
        begin
            q_q <= (q_q & ~lane_mask) | (wdata & lane_mask);
        end
    end

    assign q = q_q & IMPL_MASK;

endmodule

// >>> core/ipe_arbiter.sv
`timescale 1ns/1ns
`include "ipe_params.svh"

module ipe_arbiter
    import ipe_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [`IPE_NUM_SRC-1:0] req,
    input wire logic [`IPE_NUM_SRC-1:0] en,
    input wire logic [3*`IPE_NUM_SRC-1:0] lvl,
    output ipe_grant_t grant
);

    ipe_grant_t best;
    ipe_grant_t grant_q;

    // Strict compare: on equal levels the lower source index wins
    always_comb
    begin
        best = '{valid: 1'b0, level: `IPE_LVL_OFF, source: SRC_TIMER_ONE};
        for (int i = 0; i < `IPE_NUM_SRC; i++)
        begin
            if (req[i] && en[i] && lvl[3*i +: 3] != `IPE_LVL_OFF)
            begin
                if (lvl[3*i +: 3] > best.level)
                begin
                    best.valid = 1'b1;
                    best.level = lvl[3*i +: 3];
                    best.source = ipe_src_t'(5'(i));
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            grant_q <= '{valid: 1'b0, level: `IPE_LVL_OFF, source: SRC_TIMER_ONE};
        end
        else
        begin
            grant_q <= best;
        end
    end

    assign grant = grant_q;

endmodule

// >>> verif/ipe_chk.sv
`timescale 1ns/1ns
`include "ipe_params.svh"

module ipe_chk
    import ipe_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [`IPE_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic [`IPE_NUM_SRC-1:0] src_req,
    input wire logic [`IPE_NUM_SRC-2:0] src_enable,
    input wire logic [2:0] usb_level,
    input wire logic usb_irq_enable,
    input wire ipe_levels_t levels,
    input wire ipe_grant_t grant
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
logic [53:0] lv_all;
logic [53:0] lv_q;
logic [17:0] rq_q;
logic [17:0] en_q;
logic [7:0] ar_q;
logic [2:0] best_l;
logic [4:0] best_s;
logic [15:0] rd_msk;
////////////////////////////////////////////////////////////////
// Flat level vector, source index order
always_comb
begin
    for (int i = 0; i < 17; i++)
    begin
        lv_all[3*i+:3] = levels[3*(16-i)+:3];
    end
    lv_all[53:51] = usb_level;
end
// Arbiter samples inputs one edge before grant shows them
always_ff @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        rq_q <= '0;
        en_q <= '0;
        lv_q <= '0;
    end
    else
    begin
        rq_q <= src_req;
        en_q <= {usb_irq_enable, src_enable};
        lv_q <= lv_all;
    end
end
always_ff @(posedge clk or negedge resetn)
begin
    if (!resetn)
        ar_q <= '0;
    else if (s_axi_arvalid && s_axi_arready)
        ar_q <= s_axi_araddr;
end
always_comb
begin
    best_l = 3'h0;
    best_s = 5'h00;
    for (int i = 0; i < 18; i++)
    begin
        if (rq_q[i] && en_q[i] && lv_q[3*i+:3] > best_l)
        begin
            best_l = lv_q[3*i+:3];
            best_s = 5'(i);
        end
    end
end
// Unmapped addresses read all zero
always_comb
begin
    case (ar_q)
        8'h00: rd_msk = 16'h0040;
        8'h04, 8'h0C, 8'h14: rd_msk = 16'h7777;
        8'h08: rd_msk = 16'h7770;
        8'h10: rd_msk = 16'h0077;
        8'h18: rd_msk = 16'h81F7;
        default: rd_msk = 16'h0000;
    endcase
end
////////////////////////////////////////////////////////////////
property p_rst_val;
    $rose(resetn) |-> levels == {17{3'b100}} && !usb_irq_enable;
endproperty
a_rst_val: assert property (p_rst_val) else $error("reset value wrong");
property p_gnt_valid;
    grant.valid == (best_l != 3'h0);
endproperty
a_gnt_valid: assert property (p_gnt_valid) else $error("grant valid wrong");
property p_gnt_pick;
    grant.valid |-> grant.level == best_l && grant.source == best_s;
endproperty
a_gnt_pick: assert property (p_gnt_pick) else $error("grant pick wrong");
property p_gnt_off;
    grant.valid |-> lv_q[3*grant.source+:3] != 3'h0 && en_q[grant.source];
endproperty
a_gnt_off: assert property (p_gnt_off) else $error("disabled source granted");
property p_usb_wr;
    $changed(usb_irq_enable) |-> s_axi_bvalid;
endproperty
a_usb_wr: assert property (p_usb_wr) else $error("enable moved without write");
property p_lvl_wr;
    !$stable(levels) |-> s_axi_bvalid;
endproperty
a_lvl_wr: assert property (p_lvl_wr) else $error("level moved without write");
property p_rd_zero;
    s_axi_rvalid |-> (s_axi_rdata & ~{16'h0000, rd_msk}) == 32'h0000_0000;
endproperty
a_rd_zero: assert property (p_rd_zero) else $error("unused bits read nonzero");
property p_rd_usb;
    s_axi_rvalid && ar_q == 8'h00 |-> s_axi_rdata[6] == usb_irq_enable;
endproperty
a_rd_usb: assert property (p_rd_usb) else $error("enable readback wrong");
c_gnt: cover property (grant.valid && grant.level == 3'h7);
c_usb: cover property ($rose(usb_irq_enable));
c_rd: cover property (s_axi_rvalid && ar_q == 8'h18);
endmodule

// >>> verif/ipe_src_model.sv
`timescale 1ns/1ns

module ipe_src_model
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [17:0] cmd_req,
    input wire logic [16:0] cmd_en,
    input wire logic [2:0] cmd_lvl,
    output logic [17:0] src_req,
    output logic [16:0] src_enable,
    output logic [2:0] usb_level
);
// Sources raise and drop requests on the clock, as real peripherals do
always_ff @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        src_req <= '0;
        src_enable <= '0;
        usb_level <= 3'h4;
    end
    else
    begin
        src_req <= cmd_req;
        src_enable <= cmd_en;
        usb_level <= cmd_lvl;
    end
end
endmodule

// >>> verif/test_irq_priority_enable_regs.sv
`timescale 1ns/1ns

module test_irq_priority_enable_regs;
import ipe_pkg::*;
logic clk, resetn, awv, wv, bready, arv, rready;
logic [7:0] awaddr, araddr;
logic [31:0] wdata, d;
logic [3:0] wstrb;
logic [17:0] cmd_req;
logic [16:0] cmd_en;
logic [2:0] cmd_lvl;
wire logic awready, wready, bvalid, arready, rvalid, usb_en;
wire logic [1:0] bresp, rresp;
wire logic [31:0] rdata;
wire logic [17:0] src_req;
wire logic [16:0] src_en;
wire logic [2:0] usb_lvl;
ipe_levels_t levels;
ipe_grant_t grant;
int n_errors, n_checks;
logic [15:0] m[6];
logic [1:0] r;
logic [8:0] p;
const logic [15:0] msk[6] = '{16'h0040, 16'h7777, 16'h7770, 16'h7777, 16'h0077, 16'h7777};
const int ri[18] = '{1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4, 5, 5, 5, 5, 0};
const int sh[18] = '{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 0, 0};
ipe_src_model u_src (.clk(clk), .resetn(resetn), .cmd_req(cmd_req), .cmd_en(cmd_en),
    .cmd_lvl(cmd_lvl), .src_req(src_req), .src_enable(src_en), .usb_level(usb_lvl));
ipe_regs u_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src_req(src_req), .src_enable(src_en), .usb_level(usb_lvl),
    .usb_irq_enable(usb_en), .levels(levels), .grant(grant));
////////////////////////////////////////////////////////////////
task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
        n_errors++;
        $display("BAD %0t got %h exp %h", $time, g, e);
    end
endtask
task automatic tmo(input int n);
    if (n >= 100)
    begin
        n_errors++;
        $display("BAD %0t bus timeout", $time);
        print_verdict();
    end
endtask
task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] s);
    int n;
    bit aw, w;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    wstrb <= {2'b00, s};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    n = 0;
    aw = 0;
    w = 0;
    do
    begin
        @(posedge clk);
        n++;
        if (!aw && awready)
        begin
            aw = 1;
            awv <= 1'b0;
        end
        if (!w && wready)
        begin
            w = 1;
            wv <= 1'b0;
        end
    end while (!(aw && w) && n < 100);
    do @(posedge clk); while (!bvalid && ++n < 100);
    r = bresp;
    bready <= 1'b0;
    if (a <= 8'h14 && a[1:0] == 2'b00)
    begin
        if (s[0]) m[a[4:2]][7:0] = v[7:0];
        if (s[1]) m[a[4:2]][15:8] = v[15:8];
        m[a[4:2]] &= msk[a[4:2]];
    end
    tmo(n);
endtask
task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do @(posedge clk); while (!arready && ++n < 100);
    arv <= 1'b0;
    do @(posedge clk); while (!rvalid && ++n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(n);
endtask
task automatic check_all();
    for (int k = 0; k < 6; k++)
    begin
        rd(8'(4*k));
        chk(d, {16'h0000, m[k]});
        chk(r, 2'h0);
    end
    for (int i = 0; i < 17; i++)
        chk(levels[3*(16-i)+:3], m[ri[i]][sh[i]+:3]);
    chk(usb_en, m[0][6]);
endtask
task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    m[0] = 16'h0000;
    for (int k = 1; k < 6; k++)
        m[k] = msk[k] & 16'h4444;
endtask
// Highest level wins, lowest index on a tie
function automatic logic [8:0] pick();
    logic [2:0] bl;
    logic [4:0] bs;
    logic [17:0] en;
    logic [2:0] l;
    bl = 3'h0;
    bs = 5'h00;
    en = {m[0][6], src_en};
    for (int i = 0; i < 18; i++)
    begin
        l = (i == 17) ? usb_lvl : m[ri[i]][sh[i]+:3];
        if (src_req[i] && en[i] && l > bl)
        begin
            bl = l;
            bs = 5'(i);
        end
    end
    return {bl != 3'h0, bl, bs};
endfunction
////////////////////////////////////////////////////////////////
initial
begin
    clk = 1'b0;
    forever #10 clk = ~clk;
end
initial
begin
    {resetn, awv, wv, bready, arv, rready, awaddr, araddr, wdata, wstrb} = '0;
    {cmd_req, cmd_en, cmd_lvl} = '0;
    n_errors = 0;
    n_checks = 0;
    void'($urandom(32'h6681));
    do_reset();
    check_all();
    for (int c = 0; c < 8; c++)
        for (int k = 0; k < 6; k++)
            wr(8'(4*k), 16'(c * 16'h1111) | 16'h8888, 2'b11);
    check_all();
    for (int j = 0; j < 30; j++)
    begin
        wr(8'(4*$urandom_range(0, 5)), 16'($urandom), 2'($urandom));
        chk(r, 2'h0);
        if (j % 6 == 5)
            check_all();
    end
    wr(8'h1C, 16'hFFFF, 2'b11);
    chk(r, 2'h2);
    wr(8'h05, 16'hFFFF, 2'b11);
    chk(r, 2'h2);
    wr(8'h18, 16'hFFFF, 2'b11);
    chk(r, 2'h0);
    rd(8'h1C);
    chk(d, 32'h0000_0000);
    chk(r, 2'h2);
    check_all();
    for (int j = 0; j < 80; j++)
    begin
        wr(8'(4*$urandom_range(0, 5)), 16'($urandom), 2'b11);
        cmd_req <= 18'($urandom);
        cmd_en <= 17'($urandom);
        cmd_lvl <= 3'($urandom);
        repeat (3) @(posedge clk);
        p = pick();
        chk({23'h0, grant}, {23'h0, p});
        rd(8'h18);
        chk(d, {16'h0000, p[8], 6'h00, p[4:0], 1'b0, p[7:5]});
    end
    do_reset();
    check_all();
    print_verdict();
end
endmodule

bind ipe_regs ipe_chk u_chk (.clk(clk), .resetn(resetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
    .src_req(src_req), .src_enable(src_enable), .usb_level(usb_level),
    .usb_irq_enable(usb_irq_enable), .levels(levels), .grant(grant));
